// [design/clg_pkg.sv]
package clg_pkg;
    localparam int NCELL = 4;
    localparam int AW = 8;
    localparam int DW = 8;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [AW-1:0] OFS_MODULE_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_INT_CTRL = 8'h05;
    localparam logic [AW-1:0] OFS_INT_FLAGS = 8'h07;
    localparam logic [AW-1:0] OFS_CELL_FIRST = 8'h08;
    localparam logic [AW-1:0] OFS_CELL_LAST = 8'h17;
    localparam logic [1:0] SLOT_CELL_CONTROL = 2'h0;
    localparam logic [1:0] SLOT_SELECT_LOW = 2'h1;
    localparam logic [1:0] SLOT_SELECT_HIGH = 2'h2;
    localparam logic [1:0] SLOT_TRUTH = 2'h3;
    localparam logic [DW-1:0] RESET_VALUE = 8'h00;
    localparam logic [DW-1:0] MODULE_CTRL_MASK = 8'h41;
    localparam int MOD_ENABLE_BIT = 0;
    // ----------------------------------------
    // Cell control fields
    // ----------------------------------------
    localparam int CA_ENABLE_BIT = 0;
    localparam int CA_CLKSEL_LSB = 1;
    localparam int CA_FILT_LSB = 4;
    localparam int CA_PIN_BIT = 6;
    localparam int SEL_IN1_LSB = 4;
    localparam int SEL_IN0_LSB = 0;
    localparam int SEL_IN2_LSB = 0;
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_SYNC = 2'h1;
    localparam logic [1:0] FILT_FILTER = 2'h2;
    localparam logic [2:0] CLK_PERIPH = 3'h0;
    localparam logic [2:0] CLK_TBIT2 = 3'h1;
    localparam logic [2:0] CLK_FAST = 3'h4;
    localparam logic [2:0] CLK_SLOW = 3'h5;
    localparam logic [2:0] CLK_SLOW_DIV = 3'h6;
    localparam logic [4:0] SLOW_DIV_LAST = 5'h1f;
    localparam logic [1:0] INT_RISE = 2'h1;
    localparam logic [1:0] INT_FALL = 2'h2;
    localparam logic [1:0] INT_BOTH = 2'h3;
    // ----------------------------------------
    // Input source codes
    // ----------------------------------------
    localparam logic [3:0] SRC_MASK = 4'h0;
    localparam logic [3:0] SRC_FEEDBACK = 4'h1;
    localparam logic [3:0] SRC_LINK = 4'h2;
    localparam logic [3:0] SRC_EVENT_A = 4'h3;
    localparam logic [3:0] SRC_EVENT_B = 4'h4;
    localparam logic [3:0] SRC_PIN = 4'h5;
    localparam logic [3:0] SRC_COMPARATOR = 4'h6;
    localparam logic [3:0] SRC_ZERO_CROSS = 4'h7;
    localparam logic [3:0] SRC_SERIAL = 4'h8;
    localparam logic [3:0] SRC_SPI = 4'h9;
    localparam logic [3:0] SRC_TIMER_A = 4'ha;
    localparam logic [3:0] SRC_TIMER_B = 4'hb;
    localparam logic [3:0] SRC_TIMER_D = 4'hc;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } clg_bus_t;

    typedef struct packed {
        logic [NCELL-1:0] event_line_a;
        logic [NCELL-1:0] event_line_b;
        logic [NCELL-1:0] cell_pin_input_0;
        logic [NCELL-1:0] cell_pin_input_1;
        logic [NCELL-1:0] cell_pin_input_2;
        logic comparator_zero_output;
        logic zero_cross_three_output;
        logic serial_port_zero_tx;
        logic serial_port_one_tx;
        logic spi_unit_zero_mosi;
        logic spi_unit_zero_sck;
        logic [2:0] timer_a_unit_wo;
        logic [2:0] timer_b_unit_wo;
        logic [2:0] timer_d_unit_wo;
    } clg_src_t;
endpackage

// [design/clg_lut_cells.sv]
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module clg_lut_cells
    import clg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire clg_bus_t bus,
    output logic [DW-1:0] rdata,
    input wire clg_src_t src,
    input wire logic fast_internal_oscillator,
    input wire logic slow_internal_oscillator,
    output logic [NCELL-1:0] cell_out,
    output logic [NCELL-1:0] cell_pin_out,
    output logic [NCELL-1:0] cell_pin_oe_n,
    output logic [NCELL/2-1:0] seq_clk_en
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] cell_of(input logic [AW-1:0] a);
        logic [2:0] t;
        t = a[4:2] - 3'd2;
        return t[1:0];
    endfunction

    // Peripheral sources are assumed valid; SPI and serial legality is up to
    // the caller so no mode qualification happens here.
    function automatic logic pick_input(input logic [3:0] code, input int k, input int n,
                                        input logic fb, input logic lnk, input clg_src_t s);
        logic v;
        v = 1'b0;
        case (code)
            SRC_FEEDBACK: v = fb;
            SRC_LINK: v = lnk;
            SRC_EVENT_A: v = s.event_line_a[n];
            SRC_EVENT_B: v = s.event_line_b[n];
            SRC_PIN: begin
                v = (k == 0) ? s.cell_pin_input_0[n] :
                    (k == 1) ? s.cell_pin_input_1[n] : s.cell_pin_input_2[n];
            end
            SRC_COMPARATOR: v = s.comparator_zero_output;
            SRC_ZERO_CROSS: v = s.zero_cross_three_output;
            SRC_SERIAL: v = (k == 0) ? s.serial_port_zero_tx : s.serial_port_one_tx;
            SRC_SPI: v = (k == 2) ? s.spi_unit_zero_sck : s.spi_unit_zero_mosi;
            SRC_TIMER_A: v = s.timer_a_unit_wo[k];
            SRC_TIMER_B: v = s.timer_b_unit_wo[k];
            SRC_TIMER_D: v = s.timer_d_unit_wo[k];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [DW-1:0] mod_ctrl_q;
    logic [DW-1:0] int_ctrl_q;
    logic [NCELL-1:0] flags_q;
    logic [NCELL-1:0] flags_d;
    logic [NCELL-1:0] flag_set;
    logic [DW-1:0] ctrl_a_q [NCELL];
    logic [DW-1:0] sel_low_q [NCELL];
    logic [DW-1:0] sel_high_q [NCELL];
    logic [DW-1:0] truth_q [NCELL];
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rmux;
    logic [NCELL-1:0] out_q;
    logic [NCELL-1:0] pin_q;
    logic [NCELL-1:0] cell_clk_en;

    wire module_on = mod_ctrl_q[MOD_ENABLE_BIT];
    wire in_cells = (bus.addr >= OFS_CELL_FIRST) && (bus.addr <= OFS_CELL_LAST);
    wire [1:0] wr_cell = cell_of(bus.addr);
    wire [1:0] wr_slot = bus.addr[1:0];
    wire cell_wr = bus.wr && in_cells && !module_on;
    // Decodes shared by the write and read paths
    wire hit_module = (bus.addr == OFS_MODULE_CTRL);
    wire hit_int = (bus.addr == OFS_INT_CTRL);
    wire hit_flags = (bus.addr == OFS_INT_FLAGS);
    wire flags_wr = bus.wr && hit_flags;

    // Set wins over a simultaneous write-one clear
    assign flags_d = (flags_q & ~(flags_wr ? bus.wdata[NCELL-1:0] : '0)) | flag_set;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_ctrl_q <= RESET_VALUE;
        end else if (bus.wr && hit_module) begin
            mod_ctrl_q <= bus.wdata & MODULE_CTRL_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ctrl_q <= RESET_VALUE;
        end else if (bus.wr && hit_int) begin
            int_ctrl_q <= bus.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCELL; i++) begin
                ctrl_a_q[i] <= RESET_VALUE;
                sel_low_q[i] <= RESET_VALUE;
                sel_high_q[i] <= RESET_VALUE;
                truth_q[i] <= RESET_VALUE;
            end
        end else if (cell_wr) begin
            case (wr_slot)
                SLOT_CELL_CONTROL: ctrl_a_q[wr_cell] <= bus.wdata;
                SLOT_SELECT_LOW: sel_low_q[wr_cell] <= bus.wdata;
                SLOT_SELECT_HIGH: sel_high_q[wr_cell] <= {4'h0, bus.wdata[3:0]};
                default: truth_q[wr_cell] <= bus.wdata;
            endcase
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rmux = '0;
        if (hit_module) begin
            rmux = mod_ctrl_q;
        end else if (hit_int) begin
            rmux = int_ctrl_q;
        end else if (hit_flags) begin
            rmux = {4'h0, flags_q};
        end else if (in_cells) begin
            case (wr_slot)
                SLOT_CELL_CONTROL: rmux = ctrl_a_q[wr_cell];
                SLOT_SELECT_LOW: rmux = sel_low_q[wr_cell];
                SLOT_SELECT_HIGH: rmux = sel_high_q[wr_cell];
                default: rmux = truth_q[wr_cell];
            endcase
        end
    end

    // Zero outside the answer cycle, so a stale read never lingers on the bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= bus.rd ? rmux : '0;
        end
    end
    assign rdata = rdata_q;

    // ----------------------------------------
    // Oscillator edge enables
    // ----------------------------------------
    // Oscillators are sampled as levels, so each source must run well below
    // half of clk; the fast one is only as good as that sampling allows.
    logic fast_q;
    logic slow_q;
    logic [4:0] slow_cnt_q;
    wire fast_rise = fast_internal_oscillator & ~fast_q;
    wire slow_rise = slow_internal_oscillator & ~slow_q;
    wire slow_div_rise = slow_rise && (slow_cnt_q == SLOW_DIV_LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_q <= 1'b0;
            slow_q <= 1'b0;
        end else begin
            fast_q <= fast_internal_oscillator;
            slow_q <= slow_internal_oscillator;
        end
    end

    // Counter runs while every cell is off, so the divided tick keeps its phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt_q <= '0;
        end else if (slow_rise) begin
            slow_cnt_q <= slow_cnt_q + 5'd1;
        end
    end

    // ----------------------------------------
    // Cells
    // ----------------------------------------
    for (genvar n = 0; n < NCELL; n++) begin : g_cell
        logic in0;
        logic in1;
        logic in2;
        logic raw;
        logic tbit2_q;
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic s4_q;
        logic prev_q;
        logic out_d;
        logic [1:0] mode;
        wire [DW-1:0] ca = ctrl_a_q[n];
        wire cell_on = module_on && ca[CA_ENABLE_BIT];
        wire [2:0] csel = ca[CA_CLKSEL_LSB +: 3];
        wire [1:0] fsel = ca[CA_FILT_LSB +: 2];
        wire lnk = out_q[(n + 1) % NCELL];
        wire shift_en = cell_on && cell_clk_en[n] && (fsel == FILT_SYNC || fsel == FILT_FILTER);
        wire stage_load = !cell_on || shift_en;
        wire out_load = stage_load || fsel == FILT_NONE || fsel == 2'h3;
        wire [3:0] stages_d = cell_on ? {raw, s1_q, s2_q, s3_q} : 4'h0;
        wire out_next = cell_on && out_d;

        assign in1 = pick_input(sel_low_q[n][SEL_IN1_LSB +: 4], 1, n,
                                out_q[n], lnk, src);
        assign in0 = pick_input(sel_low_q[n][SEL_IN0_LSB +: 4], 0, n,
                                out_q[n], lnk, src);
        assign in2 = pick_input(sel_high_q[n][SEL_IN2_LSB +: 4], 2, n,
                                out_q[n], lnk, src);
        // Disabled cell forces the table output low
        assign raw = cell_on && truth_q[n][{in2, in1, in0}];

        always_comb begin
            case (csel)
                CLK_PERIPH: cell_clk_en[n] = 1'b1;
                CLK_TBIT2: cell_clk_en[n] = in2 & ~tbit2_q;
                CLK_FAST: cell_clk_en[n] = fast_rise;
                CLK_SLOW: cell_clk_en[n] = slow_rise;
                CLK_SLOW_DIV: cell_clk_en[n] = slow_div_rise;
                default: cell_clk_en[n] = 1'b0;
            endcase
        end

        // Filter holds the output until three synced samples agree
        always_comb begin
            case (fsel)
                FILT_SYNC: out_d = s2_q;
                FILT_FILTER: out_d = (s2_q == s3_q && s3_q == s4_q) ? s2_q : out_q[n];
                default: out_d = raw;
            endcase
        end

        assign mode = int_ctrl_q[2*n +: 2];
        assign flag_set[n] = (mode == INT_RISE && out_q[n] && !prev_q) ||
                             (mode == INT_FALL && !out_q[n] && prev_q) ||
                             (mode == INT_BOTH && out_q[n] != prev_q);

        // ----------------------------------------
        // Cell state
        // ----------------------------------------
        // Third input is registered so its rising edge can act as the cell clock
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                tbit2_q <= 1'b0;
                prev_q <= 1'b0;
            end else begin
                tbit2_q <= in2;
                prev_q <= out_q[n];
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pin_q[n] <= 1'b0;
            end else begin
                pin_q[n] <= cell_on && ca[CA_PIN_BIT];
            end
        end

        // Stages clear while off so a re-enabled cell never replays old samples
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                {s1_q, s2_q, s3_q, s4_q} <= 4'h0;
            end else if (stage_load) begin
                {s1_q, s2_q, s3_q, s4_q} <= stages_d;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                out_q[n] <= 1'b0;
            end else if (out_load) begin
                out_q[n] <= out_next;
            end
        end
    end

    for (genvar p = 0; p < NCELL / 2; p++) begin : g_pair
        assign seq_clk_en[p] = cell_clk_en[2*p];
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Pin copy is the registered output, so the pin never shows table glitches
    assign cell_out = out_q;
    assign cell_pin_out = out_q;
    assign cell_pin_oe_n = ~pin_q;
endmodule
`default_nettype wire

// [test/clg_src_model.sv]
`timescale 1ns/1ns
`default_nettype none
module clg_src_model
    import clg_pkg::*;
(
    input wire logic clk,
    input wire logic spi_host,
    input wire logic serial_ok,
    input wire clg_src_t want,
    output var clg_src_t src
);
    // ----
    // Far-side sources
    // ----
    // Units outside a legal mode give a line that wanders
    logic wander_q = 1'b0;
    always @(posedge clk) wander_q <= !wander_q;
    always_comb begin
        src = want;
        if (!spi_host) begin
            src.spi_unit_zero_mosi = wander_q;
            src.spi_unit_zero_sck = !wander_q;
        end
        if (!serial_ok) begin
            src.serial_port_zero_tx = wander_q;
            src.serial_port_one_tx = !wander_q;
        end
    end
endmodule
`default_nettype wire

// [test/clg_lut_cells_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module clg_lut_cells_monitor
    import clg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire clg_bus_t bus,
    input wire logic [DW-1:0] rdata,
    input wire clg_src_t src,
    input wire logic fast_internal_oscillator,
    input wire logic slow_internal_oscillator,
    input wire logic [NCELL-1:0] cell_out,
    input wire logic [NCELL-1:0] cell_pin_out,
    input wire logic [NCELL-1:0] cell_pin_oe_n,
    input wire logic [NCELL/2-1:0] seq_clk_en
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----
    // Cell 0 shadow, locked like the device
    // ----
    logic en_q;
    logic [DW-1:0] ca_q;
    logic [DW-1:0] sb_q;
    logic [DW-1:0] sc_q;
    logic [DW-1:0] tr_q;
    wire logic open_w = bus.wr && !en_q;
    wire logic ev = src.event_line_a[0];
    wire logic ev_cfg = en_q && sb_q == 8'h33 && sc_q == 8'h03;
    wire logic oe_w = en_q && ca_q[6] && ca_q[0];
    wire logic [2:0] ck = ca_q[3:1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            ca_q <= 8'h00;
            sb_q <= 8'h00;
            sc_q <= 8'h00;
            tr_q <= 8'h00;
        end else begin
            if (bus.wr && bus.addr == OFS_MODULE_CTRL) en_q <= bus.wdata[0];
            if (open_w && bus.addr == 8'h08) ca_q <= bus.wdata;
            if (open_w && bus.addr == 8'h09) sb_q <= bus.wdata;
            if (open_w && bus.addr == 8'h0a) sc_q <= bus.wdata;
            if (open_w && bus.addr == 8'h0b) tr_q <= bus.wdata;
        end
    end
    AST_TRUTH: assert property (ev_cfg && ca_q[5:4] == FILT_NONE && ca_q[0] |=>
        cell_out[0] == tr_q[{3{$past(ev)}}]) else $error("cell output off truth bit");
    AST_MASK: assert property (en_q && ca_q == 8'h01 && sb_q == 8'h00 && sc_q == 8'h00
        |=> cell_out[0] == tr_q[0]) else $error("masked inputs not zero");
    AST_SYNC: assert property ((ev_cfg && ca_q[5:0] == 6'h11 && $stable(ev))[*4]
        |-> cell_out[0] == tr_q[{3{ev}}]) else $error("synchronizer too slow");
    AST_FILT: assert property ((ev_cfg && ca_q[5:0] == 6'h21 && $stable(ev))[*6]
        |-> cell_out[0] == tr_q[{3{ev}}]) else $error("filter too slow");
    AST_OFF: assert property (!(en_q && ca_q[0]) |=> !cell_out[0])
        else $error("disabled cell drives one");
    AST_PIN: assert property (1'b1 |=> cell_pin_oe_n[0] != $past(oe_w))
        else $error("pin enable wrong");
    AST_RD: assert property (bus.rd && bus.addr == 8'h0b |=> rdata == tr_q)
        else $error("truth readback wrong");
    AST_SEQ_PER: assert property (ck == CLK_PERIPH |-> seq_clk_en[0])
        else $error("peripheral clock not every cycle");
    AST_SEQ_RSV: assert property (ck == 3'h2 || ck == 3'h3 || ck == 3'h7 |-> !seq_clk_en[0])
        else $error("reserved clock ticks");
    AST_SEQ_SLOW: assert property ((ck == CLK_SLOW && !slow_internal_oscillator)[*4]
        |-> !seq_clk_en[0]) else $error("slow clock ticks while low");
endmodule
bind clg_lut_cells clg_lut_cells_monitor clg_lut_cells_monitor_i (.clk(clk), .rst_n(rst_n),
    .bus(bus), .rdata(rdata), .src(src), .fast_internal_oscillator(fast_internal_oscillator),
    .slow_internal_oscillator(slow_internal_oscillator), .cell_out(cell_out),
    .cell_pin_out(cell_pin_out), .cell_pin_oe_n(cell_pin_oe_n), .seq_clk_en(seq_clk_en));
`default_nettype wire

// [test/test_clg_lut_cells.sv]
`timescale 1ns/1ns
`default_nettype none
module test_clg_lut_cells import clg_pkg::*;;
    // ----
    // Harness
    // ----
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] osc_q = 3'h0;
    clg_bus_t bus = '0;
    clg_src_t want = '0;
    clg_src_t src;
    logic [DW-1:0] rdata;
    logic [NCELL-1:0] cell_out;
    logic [NCELL-1:0] pin_out;
    logic [NCELL-1:0] oe_n;
    logic [1:0] seq_en;
    logic [7:0] v;
    int errors = 0;
    int comparisons = 0;
    int n;
    int cnt_tab[8] = '{256, 0, 0, 0, 64, 32, 1, 0};
    logic [15:0] exp_tab = 16'h1ff8;
    always #20 clk = !clk;
    always @(posedge clk) osc_q <= osc_q + 3'h1;
    clg_src_model clg_src_model_i (.clk(clk), .spi_host(1'b1), .serial_ok(1'b1), .want(want),
        .src(src));
    clg_lut_cells clg_lut_cells_i (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .src(src), .fast_internal_oscillator(osc_q[1]), .slow_internal_oscillator(osc_q[2]),
        .cell_out(cell_out), .cell_pin_out(pin_out), .cell_pin_oe_n(oe_n), .seq_clk_en(seq_en));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, 1'b0, a, d);
        xfer(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        xfer(1'b0, 1'b1, a, 8'h00);
        xfer(1'b0, 1'b0, a, 8'h00);
        #1 d = rdata;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Cell 0 setup; the module is off while its registers change
    task automatic cfg(input logic [7:0] ca, sb, sc, tr);
        wr(8'h00, 8'h00);
        wr(8'h08, ca);
        wr(8'h09, sb);
        wr(8'h0a, sc);
        wr(8'h0b, tr);
        wr(8'h00, 8'h01);
    endtask
    function automatic clg_src_t one_src(input int k, input logic [3:0] c);
        clg_src_t s;
        s = '0;
        case (c)
            4'h3: s.event_line_a[0] = 1'b1;
            4'h4: s.event_line_b[0] = 1'b1;
            4'h5: {s.cell_pin_input_2[0], s.cell_pin_input_1[0], s.cell_pin_input_0[0]} = 3'h1 << k;
            4'h6: s.comparator_zero_output = 1'b1;
            4'h7: s.zero_cross_three_output = 1'b1;
            4'h8: {s.serial_port_one_tx, s.serial_port_zero_tx} = (k == 0) ? 2'h1 : 2'h2;
            4'h9: {s.spi_unit_zero_sck, s.spi_unit_zero_mosi} = (k == 2) ? 2'h2 : 2'h1;
            4'ha: s.timer_a_unit_wo[k] = 1'b1;
            4'hb: s.timer_b_unit_wo[k] = 1'b1;
            4'hc: s.timer_d_unit_wo[k] = 1'b1;
            default: s = '1;
        endcase
        return s;
    endfunction
    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        stop_test;
    end
    // ----
    // Tests
    // ----
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk({12'h000, oe_n}, 16'h000f);
        chk({14'h0000, seq_en}, 16'h0003);
        for (int a = 8; a < 24; a++) begin
            rd(8'(a), v);
            chk({8'h00, v}, 16'h0000);
        end
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 16; c++) begin
                if (c == 1 || c == 2)
                    continue;
                cfg(8'h01, (k == 0) ? 8'(c) : (k == 1) ? 8'(c << 4) : 8'h00,
                    (k == 2) ? 8'(c) : 8'h00, 8'h01 << (1 << k));
                want <= one_src(k, 4'(c));
                tick(2);
                chk({15'h0000, cell_out[0]}, {15'h0000, exp_tab[c]});
            end
        end
        $display("test sources done");
        cfg(8'h41, 8'h33, 8'h03, 8'h80);
        want <= one_src(0, 4'h3);
        wr(8'h0b, 8'hff);
        rd(8'h0b, v);
        chk({8'h00, v}, 16'h0080);
        chk({14'h0000, cell_out[0], oe_n[0]}, 16'h0002);
        chk({15'h0000, pin_out[0]}, 16'h0001);
        wr(8'h00, 8'h00);
        wr(8'h05, 8'h01);
        wr(8'h0c, 8'h01);
        wr(8'h0f, 8'h01);
        cfg(8'h01, 8'h02, 8'h00, 8'h02);
        tick(3);
        chk({15'h0000, cell_out[0]}, 16'h0001);
        rd(8'h07, v);
        chk({8'h00, v}, 16'h0001);
        wr(8'h07, 8'h01);
        rd(8'h07, v);
        chk({8'h00, v}, 16'h0000);
        wr(8'h05, 8'h02);
        wr(8'h00, 8'h00);
        tick(2);
        rd(8'h07, v);
        chk({8'h00, v}, 16'h0001);
        $display("test lock link flag done");
        for (int f = 1; f < 3; f++) begin
            cfg(8'h01 | 8'(f << 4), 8'h33, 8'h03, 8'h80);
            want <= '0;
            tick(8);
            @(posedge clk);
            want <= one_src(0, 4'h3);
            tick(1);
            chk({15'h0000, cell_out[0]}, 16'h0000);
            tick(7);
            chk({15'h0000, cell_out[0]}, 16'h0001);
        end
        // Cell clocked by its own third input: nothing moves without edges there
        cfg(8'h13, 8'h03, 8'h04, 8'h22);
        want <= one_src(0, 4'h3);
        tick(8);
        chk({15'h0000, cell_out[0]}, 16'h0000);
        repeat (4) begin
            @(posedge clk);
            want.event_line_b <= 4'h1;
            @(posedge clk);
            want.event_line_b <= 4'h0;
        end
        tick(2);
        chk({15'h0000, cell_out[0]}, 16'h0001);
        $display("test filters done");
        wr(8'h00, 8'h00);
        wr(8'h0c, 8'h05);
        for (int c = 0; c < 8; c++) begin
            cfg(8'h01 | 8'(c << 1), 8'h00, 8'h00, 8'h00);
            n = 0;
            repeat (256) begin
                tick(1);
                if (seq_en[0] === 1'b1)
                    n++;
            end
            chk(16'(n), 16'(cnt_tab[c]));
        end
        $display("test clocks done");
        stop_test;
    end
endmodule
`default_nettype wire
